// >>> include/mbrf_pkg.sv
// Constants shared by the register-function frame handler
package mbrf_pkg;

  // ----------------------------------------------------------------
  // Function codes and exception values
  // ----------------------------------------------------------------
  localparam logic [7:0]  FC_READ       = 8'h03;
  localparam logic [7:0]  FC_WRITE_ONE  = 8'h06;
  localparam logic [7:0]  FC_WRITE_MANY = 8'h10;
  localparam logic [7:0]  EXC_FLAG      = 8'h80;
  localparam logic [7:0]  EXC_NONE      = 8'h00;
  localparam logic [7:0]  EXC_FUNCTION  = 8'h01;
  localparam logic [7:0]  EXC_ADDRESS   = 8'h02;
  localparam logic [7:0]  EXC_VALUE     = 8'h03;
  localparam logic [7:0]  BROADCAST_ID  = 8'h00;

  // ----------------------------------------------------------------
  // Frame check
  // ----------------------------------------------------------------
  localparam logic [15:0] CRC_PRESET    = 16'hFFFF;
  localparam logic [15:0] CRC_POLY      = 16'hA001;
  localparam logic [15:0] CRC_RESIDUE   = 16'h0000;
  localparam logic [3:0]  CRC_SHIFTS    = 4'h8;

  // ----------------------------------------------------------------
  // Quantity limits
  // ----------------------------------------------------------------
  localparam logic [15:0] QTY_MIN       = 16'h0001;
  localparam logic [15:0] READ_QTY_MAX  = 16'h007D;
  localparam logic [15:0] WRITE_QTY_MAX = 16'h007B;

  // ----------------------------------------------------------------
  // Byte positions inside a request
  // ----------------------------------------------------------------
  localparam logic [7:0]  POS_ID        = 8'h00;
  localparam logic [7:0]  POS_FC        = 8'h01;
  localparam logic [7:0]  POS_ADDR_HI   = 8'h02;
  localparam logic [7:0]  POS_ADDR_LO   = 8'h03;
  localparam logic [7:0]  POS_QTY_HI    = 8'h04;
  localparam logic [7:0]  POS_QTY_LO    = 8'h05;
  localparam logic [7:0]  POS_BCNT      = 8'h06;
  localparam logic [7:0]  POS_DATA      = 8'h07;

  // ----------------------------------------------------------------
  // Frame lengths in bytes
  // ----------------------------------------------------------------
  localparam logic [8:0]  LEN_MIN       = 9'h004;
  localparam logic [8:0]  LEN_FIXED_REQ = 9'h008;
  localparam logic [8:0]  LEN_MANY_HDR  = 9'h009;
  localparam logic [8:0]  RSP_EXC_BODY  = 9'h003;
  localparam logic [8:0]  RSP_ECHO_BODY = 9'h006;
  localparam logic [8:0]  RSP_READ_HDR  = 9'h003;
  localparam logic [8:0]  CRC_BYTES     = 9'h002;

endpackage : mbrf_pkg

// >>> core/mbrf_crc.sv
// Byte-serial CRC-16 accumulator for frame check and generation
`timescale 1ns/10ps
module mbrf_crc (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        clear,
  input  wire logic        enable,
  input  wire logic [7:0]  data,
  output logic      [15:0] crc
);

  logic [15:0] next_crc;

  // ----------------------------------------------------------------
  // One byte through eight right shifts
  // ----------------------------------------------------------------
  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0]  d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 32'(mbrf_pkg::CRC_SHIFTS); i++) begin
      r = r[0] ? ((r >> 1) ^ mbrf_pkg::CRC_POLY) : (r >> 1); // [RULE12]
    end
    return r;
  endfunction : crc_step

  // Preset wins over a byte in the same cycle
  always_comb begin
    next_crc = crc;
    if (clear) begin
      next_crc = mbrf_pkg::CRC_PRESET; // [RULE12]
    end else if (enable) begin
      next_crc = crc_step(crc, data);
    end
  end

  // Register
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      crc <= mbrf_pkg::CRC_PRESET;
    end else begin
      crc <= next_crc;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  a_crc_preset_load: assert property (clear |=> crc == 16'hFFFF) // [RULE12]
    else $error("crc not preset after clear");

endmodule : mbrf_crc

// >>> core/mbrf_core.sv
// Slave frame handler for read, write-one and write-many register functions
//
// Summary of operation
// RULE1: Only functions 3, 6 and 16 are served; others are unsupported.
// RULE2: Master read request: id, 03, start, count, CRC.
// RULE3: Frame addresses are zero-based; register N sits at address N-1.
// RULE4: Read reply: id, function, byte count, register values, CRC.
// RULE5: Each register value goes out high byte first, then low byte.
// RULE6: Exception reply: id, function with top bit set, code, CRC.
// RULE7: Master write-one request: id, 06, address, value, CRC.
// RULE8: Write-one reply echoes the request, sent after the write is done.
// RULE9: Write-many covers one contiguous block of 1 to 123 registers.
// RULE10: Master write-many: id, 16, start, count, byte count, data, CRC.
// RULE11: Write-many reply: id, function, start, count, CRC; no data.
// RULE12: CRC-16: preset ones, xor byte, shift right, xor A001 on one.
// RULE13: CRC goes out low byte first, then high byte.
// RULE14: Codes 01 function, 02 address, 03 value; bad frames get nothing.
// RULE15: Broadcast id 0 requests are executed but never answered.
// RULE16: Frames for another id are dropped silently.
// RULE17: Write-many byte count not twice the count gives code 03.
`timescale 1ns/10ps
module mbrf_core #(
  parameter int BUF_DEPTH = 256
) (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic [7:0]  slave_id,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_valid,
  input  wire logic        rx_error,
  input  wire logic        rx_frame_end,
  output logic             busy,
  output logic      [15:0] reg_addr,
  input  wire logic        reg_addr_ok,
  input  wire logic [15:0] reg_rd_data,
  output logic             reg_rd_en,
  output logic             reg_wr_en,
  output logic      [15:0] reg_wr_data,
  output logic      [7:0]  tx_data,
  output logic             tx_valid,
  output logic             tx_last,
  input  wire logic        tx_ready
);

  if (BUF_DEPTH < 255 || BUF_DEPTH > 256) begin : g_depth_check
    $error("BUF_DEPTH must hold a full frame and fit an 8-bit index");
  end

  typedef enum logic [2:0] {
    S_RX, S_DECODE, S_CHECK, S_WRITE, S_LOAD, S_SEND
  } mbrf_state_t;

  // ----------------------------------------------------------------
  // State and storage
  // ----------------------------------------------------------------
  mbrf_state_t state,     next_state;
  logic [8:0]  count,     next_count;
  logic        frame_err, next_frame_err;
  logic [7:0]  fc,        next_fc;
  logic [15:0] start,     next_start;
  logic [15:0] qty,       next_qty;
  logic [7:0]  exc,       next_exc;
  logic        bcast,     next_bcast;
  logic [7:0]  idx,       next_idx;
  logic [15:0] cur_addr,  next_cur_addr;
  logic [15:0] cur_data,  next_cur_data;
  logic [8:0]  rsp_k,     next_rsp_k;
  logic [7:0]  tx_byte,   next_tx_byte;
  logic        last_flag, next_last_flag;
  logic [7:0]  rd_lo,     next_rd_lo;
  logic [7:0]  frame_buf [BUF_DEPTH];
  logic        rx_take;
  logic        crc_clear;
  logic        crc_feed;
  logic [7:0]  crc_in;
  logic [15:0] crc_value;
  logic        reply_go;
  logic        rearm;

  // ----------------------------------------------------------------
  // Request fields and checks
  // ----------------------------------------------------------------
  logic [7:0]  frm_id, frm_fc, frm_bcnt, exc_code, last_idx;
  logic [15:0] frm_start, frm_qty;
  logic        fc_known, len_ok, frame_ok, rd_hi_slot;
  logic [8:0]  body_len;

  // Word of write data for register i, high byte first
  function automatic logic [15:0] word_at(input logic [7:0] i);
    logic [7:0] base;
    base = (fc == mbrf_pkg::FC_WRITE_ONE) ? mbrf_pkg::POS_QTY_HI
                                         : mbrf_pkg::POS_DATA;
    return {frame_buf[8'(base + {i[6:0], 1'b0})],
            frame_buf[8'(base + {i[6:0], 1'b0} + 8'h01)]}; // [RULE5]
  endfunction : word_at

  // Field decode and exception choice
  always_comb begin
    frm_id    = frame_buf[mbrf_pkg::POS_ID];
    frm_fc    = frame_buf[mbrf_pkg::POS_FC];
    frm_start = {frame_buf[mbrf_pkg::POS_ADDR_HI],
                 frame_buf[mbrf_pkg::POS_ADDR_LO]};
    frm_qty   = {frame_buf[mbrf_pkg::POS_QTY_HI],
                 frame_buf[mbrf_pkg::POS_QTY_LO]};
    frm_bcnt  = frame_buf[mbrf_pkg::POS_BCNT];
    fc_known  = frm_fc == mbrf_pkg::FC_READ ||
                frm_fc == mbrf_pkg::FC_WRITE_ONE ||
                frm_fc == mbrf_pkg::FC_WRITE_MANY; // [RULE1]
    if (frm_fc == mbrf_pkg::FC_WRITE_MANY) begin
      len_ok = count == mbrf_pkg::LEN_MANY_HDR + {1'b0, frm_bcnt};
    end else begin
      len_ok = !fc_known || count == mbrf_pkg::LEN_FIXED_REQ;
    end
    frame_ok = !frame_err && len_ok && count >= mbrf_pkg::LEN_MIN &&
               crc_value == mbrf_pkg::CRC_RESIDUE && // [RULE12] [RULE14]
               (frm_id == slave_id ||
                frm_id == mbrf_pkg::BROADCAST_ID); // [RULE16]
    if (!fc_known) begin
      exc_code = mbrf_pkg::EXC_FUNCTION; // [RULE14]
    end else if (frm_fc == mbrf_pkg::FC_READ &&
                 (frm_qty < mbrf_pkg::QTY_MIN ||
                  frm_qty > mbrf_pkg::READ_QTY_MAX)) begin
      exc_code = mbrf_pkg::EXC_VALUE; // [RULE14]
    end else if (frm_fc == mbrf_pkg::FC_WRITE_MANY &&
                 (frm_qty < mbrf_pkg::QTY_MIN ||
                  frm_qty > mbrf_pkg::WRITE_QTY_MAX || // [RULE9]
                  frm_bcnt != {frm_qty[6:0], 1'b0})) begin
      exc_code = mbrf_pkg::EXC_VALUE; // [RULE17]
    end else begin
      exc_code = mbrf_pkg::EXC_NONE;
    end
    last_idx = qty[7:0] - 8'h01;
    if (exc != mbrf_pkg::EXC_NONE) begin
      body_len = mbrf_pkg::RSP_EXC_BODY; // [RULE6]
    end else if (fc != mbrf_pkg::FC_READ) begin
      body_len = mbrf_pkg::RSP_ECHO_BODY; // [RULE8] [RULE11]
    end else begin
      body_len = mbrf_pkg::RSP_READ_HDR + {qty[7:0], 1'b0}; // [RULE4]
    end
    rd_hi_slot = exc == mbrf_pkg::EXC_NONE && fc == mbrf_pkg::FC_READ &&
                 rsp_k >= mbrf_pkg::RSP_READ_HDR && rsp_k < body_len &&
                 rsp_k[0];
  end

  // Sequencer next values
  always_comb begin
    next_state = state;           next_count = count;
    next_frame_err = frame_err;   next_fc = fc;
    next_start = start;           next_qty = qty;
    next_exc = exc;               next_bcast = bcast;
    next_idx = idx;               next_cur_addr = cur_addr;
    next_cur_data = cur_data;     next_rsp_k = rsp_k;
    next_tx_byte = tx_byte;       next_last_flag = last_flag;
    next_rd_lo = rd_lo;
    rx_take = 1'b0;  crc_clear = 1'b0;  crc_feed = 1'b0;
    reply_go = 1'b0; rearm = 1'b0;
    crc_in = (state == S_SEND) ? tx_byte : rx_data;
    unique case (state)
      S_RX: begin
        if (rx_valid) begin
          if (count < 9'(BUF_DEPTH)) begin
            rx_take    = 1'b1;
            crc_feed   = 1'b1;
            next_count = count + 9'h001;
          end else begin
            next_frame_err = 1'b1;
          end
        end
        if (rx_error) begin
          next_frame_err = 1'b1; // [RULE14]
        end
        if (rx_frame_end) begin
          if (next_count != 9'h000) begin
            next_state = S_DECODE;
          end else begin
            rearm = 1'b1;
          end
        end
      end
      S_DECODE: begin
        next_fc       = frm_fc;
        next_start    = frm_start;
        next_qty      = (frm_fc == mbrf_pkg::FC_WRITE_ONE) ?
                        mbrf_pkg::QTY_MIN : frm_qty;
        next_exc      = exc_code;
        next_bcast    = frm_id == mbrf_pkg::BROADCAST_ID;
        next_idx      = 8'h00;
        next_cur_addr = frm_start; // [RULE3]
        if (!frame_ok) begin
          rearm = 1'b1; // [RULE14] [RULE16]
        end else if (exc_code != mbrf_pkg::EXC_NONE) begin
          reply_go = 1'b1;
        end else begin
          next_state = S_CHECK;
        end
      end
      S_CHECK: begin
        if (!reg_addr_ok) begin
          next_exc = mbrf_pkg::EXC_ADDRESS; // [RULE14]
          reply_go = 1'b1;
        end else if (idx == last_idx) begin
          next_idx      = 8'h00;
          next_cur_addr = start;
          if (fc == mbrf_pkg::FC_READ) begin
            reply_go = 1'b1;
          end else begin
            next_state    = S_WRITE;
            next_cur_data = word_at(8'h00);
          end
        end else begin
          next_idx      = idx + 8'h01;
          next_cur_addr = cur_addr + 16'h0001;
        end
      end
      S_WRITE: begin
        if (idx == last_idx) begin
          reply_go = 1'b1; // [RULE8]
        end else begin
          next_idx      = idx + 8'h01;
          next_cur_addr = cur_addr + 16'h0001;
          next_cur_data = word_at(idx + 8'h01);
        end
      end
      S_LOAD: begin
        next_state     = S_SEND;
        next_last_flag = rsp_k == body_len + mbrf_pkg::CRC_BYTES - 9'h001;
        if (rsp_k == body_len) begin
          next_tx_byte = crc_value[7:0]; // [RULE13]
        end else if (rsp_k > body_len) begin
          next_tx_byte = crc_value[15:8]; // [RULE13]
        end else if (exc != mbrf_pkg::EXC_NONE) begin
          if (rsp_k == 9'h000) begin
            next_tx_byte = frame_buf[mbrf_pkg::POS_ID];
          end else if (rsp_k == 9'h001) begin
            next_tx_byte = fc | mbrf_pkg::EXC_FLAG; // [RULE6]
          end else begin
            next_tx_byte = exc;
          end
        end else if (fc != mbrf_pkg::FC_READ) begin
          next_tx_byte = frame_buf[rsp_k[7:0]]; // [RULE8] [RULE11]
        end else if (rsp_k == 9'h000) begin
          next_tx_byte = frame_buf[mbrf_pkg::POS_ID];
        end else if (rsp_k == 9'h001) begin
          next_tx_byte = fc;
        end else if (rsp_k == 9'h002) begin
          next_tx_byte = {qty[6:0], 1'b0}; // [RULE4]
        end else if (rd_hi_slot) begin
          next_tx_byte = reg_rd_data[15:8]; // [RULE5]
          next_rd_lo   = reg_rd_data[7:0];
        end else begin
          next_tx_byte  = rd_lo; // [RULE5]
          next_cur_addr = cur_addr + 16'h0001;
        end
      end
      S_SEND: begin
        if (tx_ready) begin
          crc_feed = rsp_k < body_len;
          if (last_flag) begin
            rearm = 1'b1;
          end else begin
            next_rsp_k = rsp_k + 9'h001;
            next_state = S_LOAD;
          end
        end
      end
    endcase
    // Reply start, or silence for broadcast; the decode step already
    // holds this frame's broadcast flag, not the one left from the last
    if (reply_go) begin
      next_rsp_k    = 9'h000;
      next_cur_addr = start;
      crc_clear     = 1'b1;
      next_state    = next_bcast ? S_RX : S_LOAD; // [RULE15]
      rearm         = next_bcast;
    end
    // Back to listening with an empty buffer and no last-byte mark
    if (rearm) begin
      next_state     = S_RX;
      next_count     = 9'h000;
      next_frame_err = 1'b0;
      next_last_flag = 1'b0;
      crc_clear      = 1'b1;
    end
  end

  // Sequencer registers
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state <= S_RX;       count <= 9'h000;     frame_err <= 1'b0;
      fc <= 8'h00;         start <= 16'h0000;   qty <= 16'h0000;
      exc <= 8'h00;        bcast <= 1'b0;       idx <= 8'h00;
      cur_addr <= 16'h0000; cur_data <= 16'h0000; rsp_k <= 9'h000;
      tx_byte <= 8'h00;    last_flag <= 1'b0;   rd_lo <= 8'h00;
    end else begin
      state <= next_state;       count <= next_count;
      frame_err <= next_frame_err; fc <= next_fc;
      start <= next_start;       qty <= next_qty;
      exc <= next_exc;           bcast <= next_bcast;
      idx <= next_idx;           cur_addr <= next_cur_addr;
      cur_data <= next_cur_data; rsp_k <= next_rsp_k;
      tx_byte <= next_tx_byte;   last_flag <= next_last_flag;
      rd_lo <= next_rd_lo;
    end
  end

  // Frame storage, written only while listening
  always_ff @(posedge clock) begin
    if (rx_take) begin
      frame_buf[count[7:0]] <= rx_data;
    end
  end

  // Frame check over received bytes, then over reply bytes
  mbrf_crc u_crc (
    .clock   (clock),
    .reset_n (reset_n),
    .clear   (crc_clear),
    .enable  (crc_feed),
    .data    (crc_in),
    .crc     (crc_value)
  );

  // Outputs
  assign busy        = state != S_RX;
  assign reg_addr    = cur_addr; // [RULE3]
  assign reg_wr_data = cur_data;
  assign reg_wr_en   = state == S_WRITE;
  assign reg_rd_en   = state == S_LOAD && rd_hi_slot;
  assign tx_data     = tx_byte;
  assign tx_valid    = state == S_SEND;
  assign tx_last     = last_flag;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence s_crc_lo_taken;
    tx_valid && tx_ready && rsp_k == body_len;
  endsequence
  sequence s_crc_hi_out;
    tx_valid && tx_data == crc_value[15:8] && tx_last;
  endsequence

  a_fc_served_only: assert property (reg_wr_en || state == S_CHECK |-> // [RULE1]
      fc inside {8'h03, 8'h06, 8'h10})
    else $error("unsupported function reached execution");
  a_addr_zero_based: assert property ($rose(state == S_CHECK) |-> // [RULE3]
      reg_addr == start)
    else $error("first access not at the frame address");
  a_read_byte_count: assert property (tx_valid && rsp_k == 9'h002 && // [RULE4]
      exc == 8'h00 && fc == 8'h03 |-> tx_data == {qty[6:0], 1'b0})
    else $error("read byte count wrong");
  a_read_hi_first: assert property (reg_rd_en |=> tx_valid && // [RULE5]
      tx_data == $past(reg_rd_data[15:8]))
    else $error("register high byte not sent first");
  a_exc_func_flag: assert property (tx_valid && rsp_k == 9'h001 && // [RULE6]
      exc != 8'h00 |-> tx_data == (fc | 8'h80))
    else $error("exception function code lacks top bit");
  a_write_then_reply: assert property (reg_wr_en |-> !tx_valid ##1 // [RULE8]
      !(tx_valid && rsp_k != 9'h000))
    else $error("reply overlaps register writes");
  a_write_qty_range: assert property (reg_wr_en |-> qty >= 16'h0001 && // [RULE9]
      qty <= 16'h007B)
    else $error("write count out of range");
  a_many_reply_len: assert property (tx_last && tx_valid && // [RULE11]
      fc == 8'h10 && exc == 8'h00 |-> rsp_k == 9'h007)
    else $error("write-many reply length wrong");
  a_crc_order: assert property (s_crc_lo_taken |-> ##2 s_crc_hi_out) // [RULE13]
    else $error("CRC high byte not second");
  a_crc_lo_first: assert property (tx_valid && rsp_k == body_len |-> // [RULE13]
      tx_data == crc_value[7:0])
    else $error("CRC low byte wrong");
  a_bad_fc_code: assert property (state == S_DECODE && frame_ok && // [RULE14]
      !fc_known |=> exc == 8'h01)
    else $error("unsupported function not given code 01");
  a_bcast_silent: assert property (bcast && state != S_RX |-> // [RULE15]
      !tx_valid)
    else $error("broadcast answered");
  a_foreign_drop: assert property (state == S_DECODE && // [RULE16]
      frm_id != slave_id && frm_id != 8'h00 |=> state == S_RX)
    else $error("foreign frame not dropped");
  a_bcnt_mismatch: assert property (state == S_DECODE && frame_ok && // [RULE17]
      frm_fc == 8'h10 && frm_qty >= 16'h0001 && frm_qty <= 16'h007B &&
      frm_bcnt != {frm_qty[6:0], 1'b0} |=> exc == 8'h03)
    else $error("byte count mismatch not given code 03");

endmodule : mbrf_core

// >>> test/mbrf_regs_model.sv
// Register bank standing behind the frame handler's register port
`timescale 1ns/10ps
module mbrf_regs_model (
  input  wire logic        clock,
  input  wire logic [15:0] reg_addr,
  output logic             reg_addr_ok,
  output logic      [15:0] reg_rd_data,
  input  wire logic        reg_wr_en,
  input  wire logic [15:0] reg_wr_data
);
  logic [15:0] mem [16];
  // ----
  // Storage
  // ----
  // Preset words are A500 plus the word's address
  initial begin
    for (int i = 0; i < 16; i++) begin
      mem[i] = 16'hA500 + 16'(i);
    end
  end
  // Zero-based: only addresses 0 to 15 exist
  assign reg_addr_ok = (reg_addr < 16'h0010);
  // Absent words read back as the inverted address, never a stale word
  assign reg_rd_data = reg_addr_ok ? mem[reg_addr[3:0]] : ~reg_addr;
  // One word stored per write strobe
  always @(posedge clock) begin
    if (reg_wr_en && reg_addr_ok) begin
      mem[reg_addr[3:0]] <= reg_wr_data;
    end
  end
endmodule : mbrf_regs_model

// >>> test/mbrf_core_tb_top.sv
// Self-checking bench for the register-function frame handler
`timescale 1ns/10ps
module mbrf_core_tb_top;
  typedef logic [7:0] mbrf_bq_t [$];
  logic        clock;
  logic        reset_n;
  logic [7:0]  rx_data;
  logic        rx_valid;
  logic        rx_error;
  logic        rx_frame_end;
  logic        busy;
  logic [15:0] reg_addr;
  logic        reg_addr_ok;
  logic [15:0] reg_rd_data;
  logic        reg_rd_en;
  logic        reg_wr_en;
  logic [15:0] reg_wr_data;
  logic [7:0]  tx_data;
  logic        tx_valid;
  logic        tx_last;
  logic        tx_ready;
  int          rd_pulses = 0;
  int          err_total;
  int          tests_run;

  mbrf_core i_mbrf_core (
    .clock(clock), .reset_n(reset_n), .slave_id(8'h0A),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_error(rx_error),
    .rx_frame_end(rx_frame_end), .busy(busy), .reg_addr(reg_addr),
    .reg_addr_ok(reg_addr_ok), .reg_rd_data(reg_rd_data),
    .reg_rd_en(reg_rd_en), .reg_wr_en(reg_wr_en),
    .reg_wr_data(reg_wr_data), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_last(tx_last), .tx_ready(tx_ready)
  );
  mbrf_regs_model i_mbrf_regs_model (
    .clock(clock), .reg_addr(reg_addr), .reg_addr_ok(reg_addr_ok),
    .reg_rd_data(reg_rd_data), .reg_wr_en(reg_wr_en),
    .reg_wr_data(reg_wr_data)
  );
  // ----
  // Clock and watchdog
  // ----
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // Register read strobes, counted away from the launching edge
  always @(negedge clock) begin
    if (reg_rd_en === 1'b1) begin
      rd_pulses++;
    end
  end
  // A hang is cut short well beyond the expected run length
  initial begin
    repeat (30000) @(posedge clock);
    err_total++;
    $display("FAIL t=%0t watchdog expired", $time);
    test_done();
  end
  // ----
  // Helpers
  // ----
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL t=%0t byte %h, expected %h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk1(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL t=%0t flag %b, expected %b", $time, got, exp);
    end
  endtask : chk1
  // Bytes of a packed vector, first byte in the top bits
  function automatic mbrf_bq_t fr(input logic [255:0] v, input int n);
    mbrf_bq_t q;
    for (int i = n - 1; i >= 0; i--) begin
      q.push_back(v[8*i +: 8]);
    end
    return q;
  endfunction : fr
  // Frame check: all-ones preset, reflected polynomial
  function automatic logic [15:0] crc16(input mbrf_bq_t f);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (f[i]) begin
      c ^= {8'h00, f[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    return c;
  endfunction : crc16
  // Sends a request; fault bit 0 spoils the check, bit 1 flags an error
  task automatic send(input mbrf_bq_t f, input logic [1:0] flt);
    logic [15:0] c;
    c = crc16(f);
    f.push_back(c[7:0] ^ {8{flt[0]}});
    f.push_back(c[15:8]);
    repeat (2) @(posedge clock);
    foreach (f[i]) begin
      #1;
      rx_valid = 1'b1;
      rx_data = f[i];
      rx_error = flt[1] && (i == 0);
      rx_frame_end = (i == f.size() - 1);
      @(posedge clock);
    end
    #1;
    rx_valid = 1'b0;
    rx_error = 1'b0;
    rx_frame_end = 1'b0;
  endtask : send
  // Collects a reply byte by byte against the expected body plus check
  task automatic rsp(input mbrf_bq_t e);
    logic [15:0] c;
    int n;
    c = crc16(e);
    e.push_back(c[7:0]);
    e.push_back(c[15:8]);
    tx_ready = 1'b0;
    foreach (e[i]) begin
      n = 0;
      @(negedge clock);
      while (tx_valid !== 1'b1 && n < 400) begin
        @(negedge clock);
        n++;
      end
      chk1(tx_valid, 1'b1);
      chk1(busy, 1'b1);
      chk8(tx_data, e[i]);
      chk1(tx_last, i == e.size() - 1);
      // First byte is held back one cycle and must stand meanwhile
      if (i == 0) begin
        @(posedge clock);
        #1;
        tx_ready = 1'b1;
        @(negedge clock);
        chk1(tx_valid, 1'b1);
        chk8(tx_data, e[i]);
      end
      @(posedge clock);
    end
  endtask : rsp
  task automatic quiet();
    repeat (80) begin
      @(negedge clock);
      chk1(tx_valid, 1'b0);
    end
    chk1(busy, 1'b0);
    chk1(tx_last, 1'b0);
  endtask : quiet
  task automatic exc(input mbrf_bq_t f, input logic [23:0] e);
    send(f, 2'b00);
    rsp(fr({232'h0, e}, 3));
  endtask : exc
  // ----
  // Scenarios
  // ----
  task automatic t_read();
    int r0;
    r0 = rd_pulses;
    send(fr(48'h0A_03_0002_0003, 6), 2'b00);
    rsp(fr(72'h0A_03_06_A502_A503_A504, 9));
    chk8(8'(rd_pulses - r0), 8'h03);
    $display("read test done");
  endtask : t_read
  task automatic t_write_one();
    send(fr(48'h0A_06_0005_1234, 6), 2'b00);
    rsp(fr(48'h0A_06_0005_1234, 6));
    send(fr(48'h0A_03_0005_0001, 6), 2'b00);
    rsp(fr(40'h0A_03_02_1234, 5));
    $display("write one test done");
  endtask : t_write_one
  task automatic t_write_many();
    send(fr(88'h0A_10_0008_0002_04_BEEF_CAFE, 11), 2'b00);
    rsp(fr(48'h0A_10_0008_0002, 6));
    send(fr(48'h0A_03_0007_0003, 6), 2'b00);
    rsp(fr(72'h0A_03_06_A507_BEEF_CAFE, 9));
    $display("write many test done");
  endtask : t_write_many
  task automatic t_except();
    exc(fr(48'h0A_04_0000_0001, 6), 24'h0A_84_01);
    exc(fr(48'h0A_01_0000_0001, 6), 24'h0A_81_01);
    exc(fr(48'h0A_03_000F_0002, 6), 24'h0A_83_02);
    exc(fr(48'h0A_03_0000_007E, 6), 24'h0A_83_03);
    exc(fr(48'h0A_06_0010_0001, 6), 24'h0A_86_02);
    exc(fr(56'h0A_10_0000_0000_00, 7), 24'h0A_90_03);
    exc(fr(80'h0A_10_0000_0001_03_112233, 10), 24'h0A_90_03);
    exc(fr(88'h0A_10_000F_0002_04_1111_2222, 11), 24'h0A_90_02);
    send(fr(48'h0A_03_000F_0001, 6), 2'b00);
    rsp(fr(40'h0A_03_02_A50F, 5));
    $display("exception test done");
  endtask : t_except
  task automatic t_silent();
    send(fr(48'h00_06_0003_7788, 6), 2'b00);
    quiet();
    send(fr(48'h00_04_0000_0001, 6), 2'b00);
    quiet();
    send(fr(48'h0B_06_0004_5555, 6), 2'b00);
    quiet();
    send(fr(48'h0A_06_0004_6666, 6), 2'b01);
    quiet();
    send(fr(48'h0A_06_0004_6666, 6), 2'b10);
    quiet();
    send(fr(48'h0A_03_0003_0002, 6), 2'b00);
    rsp(fr(56'h0A_03_04_7788_A504, 7));
    $display("silent test done");
  endtask : t_silent
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done
  // ----
  // Main sequence
  // ----
  initial begin
    err_total = 0;
    tests_run = 0;
    reset_n = 1'b0;
    rx_data = 8'h00;
    rx_valid = 1'b0;
    rx_error = 1'b0;
    rx_frame_end = 1'b0;
    tx_ready = 1'b1;
    repeat (10) @(posedge clock);
    #1;
    reset_n = 1'b1;
    chk1(busy, 1'b0);
    chk1(tx_valid, 1'b0);
    t_read();
    t_write_one();
    t_write_many();
    t_except();
    t_silent();
    test_done();
  end
endmodule : mbrf_core_tb_top
